// [rtl/pmr_map.vh]
`ifndef PMR_MAP_VH
`define PMR_MAP_VH
// ==========================================================
// register offsets on the device register port
`define PMR_C_VRMS 12'h24d
`define PMR_C_WATT 12'h250
`define PMR_C_VAR 12'h251
`define PMR_C_VA 12'h252
`define PMR_C_FVAR 12'h254
`define PMR_C_PF 12'h256
`define PMR_C_REGION 12'h25d
`define PMR_N_WAVE 12'h265
`define PMR_N_RMS 12'h266
`define PMR_ISUM_RMS 12'h269
`define PMR_VERSION 12'h26a
`define PMR_A_WATT_ACC 12'h2e5
`define PMR_A_WATT_LO 12'h2e6
`define PMR_A_WATT_HI 12'h2e7
`define PMR_A_VAR_ACC 12'h2ef
`define PMR_A_VAR_LO 12'h2f0
`define PMR_A_VAR_HI 12'h2f1
`define PMR_A_VA_ACC 12'h2f9
`define PMR_A_VA_LO 12'h2fa
`define PMR_A_VA_HI 12'h2fb
`define PMR_A_FVAR_ACC 12'h30d
`define PMR_A_FVAR_LO 12'h30e
`define PMR_A_FVAR_HI 12'h30f
`define PMR_B_WATT_ACC 12'h321
`define PMR_B_WATT_LO 12'h322
`define PMR_B_WATT_HI 12'h323
`define PMR_B_VAR_ACC 12'h32b
// ==========================================================
// reset values
`define PMR_RST_ZERO 32'h00000000
`define PMR_RST_REGION 32'h0000000f
// version code shown once running; value is arbitrary
`define PMR_VERSION_VAL 32'h00000001
// ==========================================================
// energy_power_config fields
`define PMR_EPC_ACC_EN 0
`define PMR_EPC_RST_MODE 1
// ==========================================================
// timing
`define PMR_CLK_HZ 25000000
`define PMR_SAMPLE_HZ 4000
`define PMR_PF_PERIOD_MS 1024
`define PMR_PF_SAMPLES (`PMR_PF_PERIOD_MS * `PMR_SAMPLE_HZ / 1000)
`define PMR_CLK_PER_SAMPLE (`PMR_CLK_HZ / `PMR_SAMPLE_HZ)
`endif

// [rtl/pmr_regs.v]
// Overview of operation
// - phase C voltage rms register refreshes every 4 kSPS sample
// - phase C active and reactive power registers refresh every 4 kSPS sample
// - phase C apparent and fundamental reactive power refresh every sample
// - phase C power factor refreshes once per 1.024 s only
// - region register shows calibration set in use when multipoint enabled; resets 0xf
// - neutral current waveform register refreshes every 4 kSPS sample
// - neutral current rms has its own read-only register
// - current-sum rms has its own read-only register
// - version reads valid only after run is set; software must set run first
// - power accumulators latch after programmed count of 4 kSPS samples
// - each energy except phase B reactive is a low and a high 32-bit register at consecutive offsets
// - energy pairs update per energy/power config and accumulation time
// - all result registers 32-bit, read-only, zero at reset except region
// - current-sum rms above threshold raises mismatch flag
`timescale 1ns/1ns
`include "pmr_map.vh"

// ==========================================================
// one power channel: sample accumulator plus energy pair
module pmr_chan (
  input wire core_clk,
  input wire nrst,
  input wire sample_en,
  input wire pwr_done,
  input wire egy_done,
  input wire egy_en,
  input wire egy_rst_mode,
  input wire [31:0] power_in,
  output wire [31:0] accum,
  output wire [31:0] energy_lo,
  output wire [31:0] energy_hi
);
  reg [31:0] pwr_sum_q;
  reg [31:0] accum_q;
  reg [63:0] egy_sum_q;
  reg [31:0] lo_q;
  reg [31:0] hi_q;
  wire [63:0] power_ext;
  wire [63:0] egy_next;

  assign power_ext = {{32{power_in[31]}}, power_in};
  assign egy_next = egy_sum_q + power_ext;

  // power accumulation; the closing sample is folded into the result
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_sum_q <= `PMR_RST_ZERO;
      accum_q <= `PMR_RST_ZERO;
    end else if (sample_en) begin
      if (pwr_done) begin
        accum_q <= pwr_sum_q + power_in;
        pwr_sum_q <= `PMR_RST_ZERO;
      end else begin
        pwr_sum_q <= pwr_sum_q + power_in;
      end
    end
  end

  // energy accumulation; both halves load together so a host
  // reading low then high between updates sees one value
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      egy_sum_q <= 64'h0000000000000000;
      lo_q <= `PMR_RST_ZERO;
      hi_q <= `PMR_RST_ZERO;
    end else if (sample_en && egy_en) begin
      if (egy_done) begin
        lo_q <= egy_next[31:0];
        hi_q <= egy_next[63:32];
        if (egy_rst_mode) begin
          egy_sum_q <= 64'h0000000000000000;
        end else begin
          egy_sum_q <= egy_next;
        end
      end else begin
        egy_sum_q <= egy_next;
      end
    end
  end

  assign accum = accum_q;
  assign energy_lo = lo_q;
  assign energy_hi = hi_q;
endmodule

// ==========================================================
// result register bank
module pmr_regs #(
  parameter CLK_PER_SAMPLE = `PMR_CLK_PER_SAMPLE
) (
  input wire core_clk,
  input wire nrst,
  input wire run,
  input wire multipoint_comp_enable,
  input wire [15:0] power_accum_sample_count,
  input wire [15:0] energy_accum_time,
  input wire [1:0] energy_power_config,
  input wire [31:0] current_sum_threshold,
  input wire [31:0] c_vrms_in,
  input wire [31:0] c_watt_in,
  input wire [31:0] c_var_in,
  input wire [31:0] c_va_in,
  input wire [31:0] c_fvar_in,
  input wire [31:0] c_pf_in,
  input wire [3:0] c_region_in,
  input wire [31:0] n_wave_in,
  input wire [31:0] n_rms_in,
  input wire [31:0] isum_rms_in,
  input wire [31:0] a_watt_in,
  input wire [31:0] a_var_in,
  input wire [31:0] a_va_in,
  input wire [31:0] a_fvar_in,
  input wire [31:0] b_watt_in,
  input wire [31:0] b_var_in,
  input wire rd_en,
  input wire [11:0] rd_addr,
  output wire [31:0] rd_data,
  output wire rd_ack,
  output wire current_sum_mismatch_flag
);
  // ========================================================
  // sample rate divider
  reg [15:0] div_q;
  reg sample_en_q;
  wire div_last;

  assign div_last = (div_q == CLK_PER_SAMPLE[15:0] - 16'h0001);

  // the divider idles while stopped so the first sample after
  // run lands a full period later, never on a stale phase
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 16'h0000;
      sample_en_q <= 1'b0;
    end else if (!run) begin
      div_q <= 16'h0000;
      sample_en_q <= 1'b0;
    end else begin
      div_q <= div_last ? 16'h0000 : div_q + 16'h0001;
      sample_en_q <= div_last;
    end
  end

  // ========================================================
  // sample counters for power, energy and power factor
  reg [15:0] pwr_cnt_q;
  reg [15:0] egy_cnt_q;
  reg [11:0] pf_cnt_q;
  wire [16:0] pwr_cnt_nx;
  wire [16:0] egy_cnt_nx;
  wire pwr_done;
  wire egy_done;
  wire pf_done;
  wire egy_en;
  wire egy_rst_mode;

  assign pwr_cnt_nx = {1'b0, pwr_cnt_q} + 17'h00001;
  assign egy_cnt_nx = {1'b0, egy_cnt_q} + 17'h00001;
  // a zero count behaves as one sample per interval
  assign pwr_done = (pwr_cnt_nx >= {1'b0, power_accum_sample_count});
  assign egy_done = (egy_cnt_nx >= {1'b0, energy_accum_time});
  assign pf_done = (pf_cnt_q == `PMR_PF_SAMPLES - 1);
  assign egy_en = energy_power_config[`PMR_EPC_ACC_EN];
  assign egy_rst_mode = energy_power_config[`PMR_EPC_RST_MODE];

  // counters move only on sample pulses; while run is low they hold,
  // so an interval resumes where it stopped rather than restarting
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_cnt_q <= 16'h0000;
      egy_cnt_q <= 16'h0000;
      pf_cnt_q <= 12'h000;
    end else if (sample_en_q) begin
      pwr_cnt_q <= pwr_done ? 16'h0000 : pwr_cnt_nx[15:0];
      if (egy_en) begin
        egy_cnt_q <= egy_done ? 16'h0000 : egy_cnt_nx[15:0];
      end
      pf_cnt_q <= pf_cnt_q + 12'h001;
    end
  end

  // ========================================================
  // instantaneous results, refreshed on each sample
  reg [31:0] c_vrms_q;
  reg [31:0] c_watt_q;
  reg [31:0] c_var_q;
  reg [31:0] c_va_q;
  reg [31:0] c_fvar_q;
  reg [31:0] c_pf_q;
  reg [31:0] c_region_q;
  reg [31:0] n_wave_q;
  reg [31:0] n_rms_q;
  reg [31:0] isum_rms_q;
  reg [31:0] version_q;
  reg mismatch_q;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c_vrms_q <= `PMR_RST_ZERO;
      c_watt_q <= `PMR_RST_ZERO;
      c_var_q <= `PMR_RST_ZERO;
      c_va_q <= `PMR_RST_ZERO;
      c_fvar_q <= `PMR_RST_ZERO;
      n_wave_q <= `PMR_RST_ZERO;
      n_rms_q <= `PMR_RST_ZERO;
      isum_rms_q <= `PMR_RST_ZERO;
    end else if (sample_en_q) begin
      c_vrms_q <= c_vrms_in;
      c_watt_q <= c_watt_in;
      c_var_q <= c_var_in;
      c_va_q <= c_va_in;
      c_fvar_q <= c_fvar_in;
      n_wave_q <= n_wave_in;
      n_rms_q <= n_rms_in;
      isum_rms_q <= isum_rms_in;
    end
  end

  // power factor is slow on purpose: it follows the 1.024 s period
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c_pf_q <= `PMR_RST_ZERO;
    end else if (sample_en_q && pf_done) begin
      c_pf_q <= c_pf_in;
    end
  end

  // region falls back to its reset code while multipoint is off
  // only the low nibble carries the set number; upper bits read zero
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c_region_q <= `PMR_RST_REGION;
    end else if (!multipoint_comp_enable) begin
      c_region_q <= `PMR_RST_REGION;
    end else if (sample_en_q) begin
      c_region_q <= {28'h0000000, c_region_in};
    end
  end

  // version reads zero until measurements have been started
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      version_q <= `PMR_RST_ZERO;
    end else if (run) begin
      version_q <= `PMR_VERSION_VAL;
    end
  end

  // mismatch level follows the latched sum rms against threshold
  // a level only; any sticky status bit is kept by the status logic
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= (isum_rms_q > current_sum_threshold);
    end
  end

  // ========================================================
  // accumulated power and energy channels
  wire [31:0] a_watt_acc;
  wire [31:0] a_watt_lo;
  wire [31:0] a_watt_hi;
  wire [31:0] a_var_acc;
  wire [31:0] a_var_lo;
  wire [31:0] a_var_hi;
  wire [31:0] a_va_acc;
  wire [31:0] a_va_lo;
  wire [31:0] a_va_hi;
  wire [31:0] a_fvar_acc;
  wire [31:0] a_fvar_lo;
  wire [31:0] a_fvar_hi;
  wire [31:0] b_watt_acc;
  wire [31:0] b_watt_lo;
  wire [31:0] b_watt_hi;
  wire [31:0] b_var_acc;
  wire [191:0] ch_pwr;
  wire [191:0] ch_acc;
  wire [191:0] ch_lo;
  wire [191:0] ch_hi;

  assign ch_pwr = {b_var_in, b_watt_in, a_fvar_in, a_va_in, a_var_in, a_watt_in};
  assign {b_var_acc, b_watt_acc, a_fvar_acc, a_va_acc, a_var_acc, a_watt_acc} = ch_acc;
  assign {a_fvar_lo, a_va_lo, a_var_lo, a_watt_lo} = ch_lo[127:0];
  assign {a_fvar_hi, a_va_hi, a_var_hi, a_watt_hi} = ch_hi[127:0];
  assign b_watt_lo = ch_lo[159:128];
  assign b_watt_hi = ch_hi[159:128];

  // six identical channels share the interval counters, so every
  // accumulator and energy pair closes on the same sample;
  // the phase B reactive pair is kept internal and has no offset here,
  // which leaves its energy halves unread on purpose
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_chan
      // the last channel's energy pair is left unmapped
      pmr_chan u_chan (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_en(sample_en_q),
        .pwr_done(pwr_done),
        .egy_done(egy_done),
        .egy_en(egy_en),
        .egy_rst_mode(egy_rst_mode),
        .power_in(ch_pwr[gi*32 +: 32]),
        .accum(ch_acc[gi*32 +: 32]),
        .energy_lo(ch_lo[gi*32 +: 32]),
        .energy_hi(ch_hi[gi*32 +: 32])
      );
    end
  endgenerate

  // ========================================================
  // read port: data and ack one cycle after the strobe
  reg [31:0] rd_mux;
  reg [31:0] rd_data_q;
  reg rd_ack_q;

  // unmapped offsets read zero; writes have no path here
  always @* begin
    rd_mux = `PMR_RST_ZERO;
    case (rd_addr)
      `PMR_C_VRMS: rd_mux = c_vrms_q;
      `PMR_C_WATT: rd_mux = c_watt_q;
      `PMR_C_VAR: rd_mux = c_var_q;
      `PMR_C_VA: rd_mux = c_va_q;
      `PMR_C_FVAR: rd_mux = c_fvar_q;
      `PMR_C_PF: rd_mux = c_pf_q;
      `PMR_C_REGION: rd_mux = c_region_q;
      `PMR_N_WAVE: rd_mux = n_wave_q;
      `PMR_N_RMS: rd_mux = n_rms_q;
      `PMR_ISUM_RMS: rd_mux = isum_rms_q;
      `PMR_VERSION: rd_mux = version_q;
      `PMR_A_WATT_ACC: rd_mux = a_watt_acc;
      `PMR_A_WATT_LO: rd_mux = a_watt_lo;
      `PMR_A_WATT_HI: rd_mux = a_watt_hi;
      `PMR_A_VAR_ACC: rd_mux = a_var_acc;
      `PMR_A_VAR_LO: rd_mux = a_var_lo;
      `PMR_A_VAR_HI: rd_mux = a_var_hi;
      `PMR_A_VA_ACC: rd_mux = a_va_acc;
      `PMR_A_VA_LO: rd_mux = a_va_lo;
      `PMR_A_VA_HI: rd_mux = a_va_hi;
      `PMR_A_FVAR_ACC: rd_mux = a_fvar_acc;
      `PMR_A_FVAR_LO: rd_mux = a_fvar_lo;
      `PMR_A_FVAR_HI: rd_mux = a_fvar_hi;
      `PMR_B_WATT_ACC: rd_mux = b_watt_acc;
      `PMR_B_WATT_LO: rd_mux = b_watt_lo;
      `PMR_B_WATT_HI: rd_mux = b_watt_hi;
      `PMR_B_VAR_ACC: rd_mux = b_var_acc;
      default: rd_mux = `PMR_RST_ZERO;
    endcase
  end

  // data holds between reads so a slow host may sample late
  // a strobe on every cycle is served back to back without a wait
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= `PMR_RST_ZERO;
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign rd_data = rd_data_q;
  assign rd_ack = rd_ack_q;
  assign current_sum_mismatch_flag = mismatch_q;
endmodule

// [sim/pmr_regs_checker.sv]
`timescale 1ns/1ns
`include "pmr_map.vh"
// ==========================================================
// port-level checks of the result register bank
module pmr_regs_checker (
  input wire core_clk,
  input wire nrst,
  input wire run,
  input wire multipoint_comp_enable,
  input wire rd_en,
  input wire [11:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_ack,
  input wire current_sum_mismatch_flag
);
  // run seen since reset; results sit at reset values until then
  reg ran_q;
  wire ran_d = ran_q | run;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ran_q <= 1'b0;
    end else begin
      ran_q <= ran_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_ack_on_read: assert property (rd_en |=> rd_ack)
    else $error("read not answered");
  chk_ack_no_read: assert property (!rd_en |=> !rd_ack)
    else $error("stray ack");
  chk_data_holds: assert property (!rd_ack |-> $stable(rd_data))
    else $error("read data moved");
  chk_unmapped_zero: assert property (rd_en && rd_addr == 12'h000 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  chk_idle_zero: assert property (rd_en && !ran_q && rd_addr != `PMR_C_REGION &&
    rd_addr != `PMR_VERSION |=> rd_data == 32'h0) else $error("result not zero");
  chk_region_idle: assert property (rd_en && rd_addr == `PMR_C_REGION &&
    !multipoint_comp_enable && !$past(multipoint_comp_enable) |=> rd_data == 32'hf)
    else $error("region not idle value");
  chk_version_code: assert property (rd_en && rd_addr == `PMR_VERSION |=>
    rd_data == ($past(ran_q) ? `PMR_VERSION_VAL : 32'h0)) else $error("bad version");
  chk_no_early_flag: assert property (!ran_q |-> !current_sum_mismatch_flag)
    else $error("flag before run");
  cover property (rd_ack && rd_data != 32'h0);
  cover property ($rose(current_sum_mismatch_flag));
  cover property (rd_en && ran_q && rd_addr == `PMR_VERSION);
endmodule
bind pmr_regs pmr_regs_checker u_pmr_regs_checker (.core_clk(core_clk), .nrst(nrst), .run(run),
  .multipoint_comp_enable(multipoint_comp_enable), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_ack(rd_ack), .current_sum_mismatch_flag(current_sum_mismatch_flag));

// [sim/tb_pmr_regs.sv]
`timescale 1ns/1ns
`include "pmr_map.vh"
module tb_pmr_regs;
  // ==========================================================
  // stimulus; 8 clocks a sample keeps the 1.024 s period short
  localparam CPS = 8;
  localparam [203:0] ADR = {12'h32b, 12'h321, 12'h30d, 12'h2f9, 12'h2ef, 12'h2e5, 12'h26a,
    12'h25d, 12'h269, 12'h266, 12'h265, 12'h256, 12'h254, 12'h252, 12'h251, 12'h250, 12'h24d};
  reg core_clk = 1'b0, nrst = 1'b0, run = 1'b0, mce = 1'b0, rd_en = 1'b0;
  reg [11:0] rd_addr = 12'h000, j;
  reg [15:0] pasc = 16'h0004, eat = 16'h0006;
  reg [1:0] epc = 2'h3;
  reg [31:0] thr = 32'hffffffff, seed, old;
  reg [3:0] region = 4'h0;
  reg [31:0] din [0:14];
  wire [31:0] rd_data;
  wire rd_ack, mism;
  integer fail_count = 0, cmp_count = 0, cyc = 0, i;
  pmr_regs #(.CLK_PER_SAMPLE(CPS)) u_pmr_regs (
    .core_clk(core_clk), .nrst(nrst), .run(run), .multipoint_comp_enable(mce),
    .power_accum_sample_count(pasc), .energy_accum_time(eat), .energy_power_config(epc),
    .current_sum_threshold(thr), .c_vrms_in(din[0]), .c_watt_in(din[1]), .c_var_in(din[2]),
    .c_va_in(din[3]), .c_fvar_in(din[4]), .c_pf_in(din[5]), .c_region_in(region),
    .n_wave_in(din[6]), .n_rms_in(din[7]), .isum_rms_in(din[8]), .a_watt_in(din[9]),
    .a_var_in(din[10]), .a_va_in(din[11]), .a_fvar_in(din[12]), .b_watt_in(din[13]),
    .b_var_in(din[14]), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_ack(rd_ack), .current_sum_mismatch_flag(mism));
  // clock and hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  // ==========================================================
  // helpers
  function [11:0] ad(input integer k);
    ad = ADR[12*k +: 12];
  endfunction
  // energy over n samples of one level, as a signed 64-bit sum
  function [31:0] egy(input [31:0] w, input [7:0] n, input h);
    reg [63:0] s;
    begin
      s = {{32{w[31]}}, w} * {56'h0, n};
      egy = h ? s[63:32] : s[31:0];
    end
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // strobe for one edge; data only counts in the single ack cycle,
  // and a clock edge passes before the next strobe may rise
  task rd(input [11:0] a, input [31:0] e);
    begin
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge core_clk);
      cmp((rd_ack === 1'b1) ? rd_data : ~e, e);
      rd_en = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task waits(input integer n);
    repeat (n * CPS) @(negedge core_clk);
  endtask
  task test_done;
    begin
      $display("checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = $urandom(32'hcf55c367);
    for (i = 0; i < 15; i = i + 1)
      din[i] = $urandom;
    din[8][0] = 1'b1;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    // inputs are ignored before run, so everything shows its reset value
    for (i = 0; i < 17; i = i + 1)
      for (j = 0; j < 3; j = j + 1)
        if (j == 0 || (i > 10 && i < 16)) rd(ad(i) + j, (i == 9) ? 32'hf : 32'h0);
    rd(12'h000, 32'h0);
    run = 1'b1;
    waits(20);
    for (i = 0; i < 9; i = i + 1)
      rd(ad(i), (i == 5) ? 32'h0 : din[i]);
    rd(ad(10), `PMR_VERSION_VAL);
    for (i = 11; i < 17; i = i + 1) begin
      rd(ad(i), din[i-2] * 32'h00000004);
      if (i < 16) begin
        rd(ad(i) + 12'h1, egy(din[i-2], 8'h06, 1'b0));
        rd(ad(i) + 12'h2, egy(din[i-2], 8'h06, 1'b1));
      end
    end
    // energy freezes with accumulation off, the power sum keeps going
    epc = 2'h0;
    old = egy(din[9], 8'h06, 1'b0);
    din[9] = $urandom;
    waits(10);
    rd(ad(11) + 12'h1, old);
    rd(ad(11), din[9] * 32'h00000004);
    seed = $urandom;
    region = seed[3:0];
    mce = 1'b1;
    waits(2);
    rd(ad(9), {28'h0, region});
    // threshold compare is strictly greater
    thr = din[8];
    waits(2);
    cmp({31'h0, mism}, 32'h0);
    thr = din[8] - 32'h00000001;
    waits(2);
    cmp({31'h0, mism}, 32'h1);
    waits(3950);
    rd(ad(5), 32'h0);
    waits(150);
    rd(ad(5), din[5]);
    // second reset mid-run; energy now sums across latches with clear off
    nrst = 1'b0;
    epc = 2'h1;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    rd(ad(10), 32'h00000000);
    rd(ad(5), 32'h00000000);
    waits(20);
    rd(ad(11) + 12'h1, egy(din[9], 8'h12, 1'b0));
    rd(ad(11) + 12'h2, egy(din[9], 8'h12, 1'b1));
    test_done;
  end
endmodule
